// ===== rtl/cfs_supervisor.sv
/*
 * cfs_supervisor: fault supervision and telemetry for a buck converter.
 * Holds limit, action, mask and status registers reached by command code,
 * compares temperature and feedback samples, runs the on/off sequence,
 * raises the alert and drives the open-drain power-good pin.
 * Assumes samples, command strobes and the soft-start done level are
 * synchronous to i_ref_clk; the command protocol engine lives outside.
 */
`timescale 1ns/1ps
module cfs_supervisor
    import cfs_pkg::*;
#(
    parameter int P_MS_CYCLES = cfs_pkg::MS_CYCLES
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_resetn,
    input  wire logic             i_ce,
    input  wire cfs_pkg::cfs_cmd_s i_cmd,
    input  wire logic             i_turn_on,
    input  wire logic             i_temp_valid,
    input  wire logic [15:0]      i_temp_c,
    input  wire logic             i_bg_valid,
    input  wire logic [15:0]      i_bg_temp_c,
    input  wire logic             i_fb_valid,
    input  wire logic [15:0]      i_fb_mv,
    input  wire logic [15:0]      i_vref_mv,
    input  wire logic [7:0]       i_rise_ms,
    input  wire logic             i_ss_done,
    output logic [15:0]           o_cmd_rdata,
    output logic                  o_conv_en,
    output logic                  o_lowside_on,
    output logic                  o_smbalert_n,
    output logic                  o_pwr_ok_o,
    output logic                  o_pwr_ok_oe
);
    import cfs_pkg::*;

    // registers
    logic [15:0] ot_fault_r, ot_warn_r, ton_max_r, die_temp_r, vout_rd_r, fb_r;
    logic [7:0]  pct_r, mask_r, therm_st_r, vend_st_r, vout_st_r;
    logic [1:0]  th_act_r, ov_act_r, uv_act_r;
    logic [17:0] avg_acc_r;
    logic [1:0]  avg_cnt_r;
    logic        bg_hold_r, ot_hold_r;
    cfs_state_e  st_r, st_nxt;

    // command decode
    logic wr_otf, wr_otw, wr_ton, wr_pct, wr_tha, wr_ova, wr_uva, wr_msk;
    logic clr_th, clr_vd, clr_vo;
    assign wr_otf = i_cmd.wr && i_cmd.code == CMD_OT_FAULT_LIM;
    assign wr_otw = i_cmd.wr && i_cmd.code == CMD_OT_WARN_LIM;
    assign wr_ton = i_cmd.wr && i_cmd.code == CMD_TON_MAX_LIM;
    assign wr_pct = i_cmd.wr && i_cmd.code == CMD_PCT_LIMITS;
    assign wr_tha = i_cmd.wr && i_cmd.code == CMD_THERM_ACTION;
    assign wr_ova = i_cmd.wr && i_cmd.code == CMD_OV_ACTION;
    assign wr_uva = i_cmd.wr && i_cmd.code == CMD_UV_ACTION;
    assign wr_msk = i_cmd.wr && i_cmd.code == CMD_ALERT_MASK;
    assign clr_th = i_cmd.wr && i_cmd.code == CMD_THERM_STATUS;
    assign clr_vd = i_cmd.wr && i_cmd.code == CMD_VENDOR_STATUS;
    assign clr_vo = i_cmd.wr && i_cmd.code == CMD_VOUT_STATUS;

    // voltage thresholds from preset shifts of the reference; prebias from a fixed 13/256 multiple
    logic [1:0]  sel_ovf, sel_ovw, sel_uvw, sel_uvf;
    logic [15:0] thr_ovf, thr_ovw, thr_uvw, thr_uvf, thr_pre;
    logic [19:0] pre_prod;
    assign sel_ovf  = pct_r[PCT_OVF_LSB +: 2];
    assign sel_ovw  = pct_r[PCT_OVW_LSB +: 2];
    assign sel_uvw  = pct_r[PCT_UVW_LSB +: 2];
    assign sel_uvf  = pct_r[PCT_UVF_LSB +: 2];
    assign thr_ovf  = i_vref_mv + (i_vref_mv >> (sel_ovf + FAULT_SHIFT0));
    assign thr_ovw  = i_vref_mv + (i_vref_mv >> (sel_ovw + WARN_SHIFT0));
    assign thr_uvw  = i_vref_mv - (i_vref_mv >> (sel_uvw + WARN_SHIFT0));
    assign thr_uvf  = i_vref_mv - (i_vref_mv >> (sel_uvf + FAULT_SHIFT0));
    assign pre_prod = {4'h0, i_vref_mv} * PREBIAS_NUM;
    assign thr_pre  = i_vref_mv + pre_prod[19:8];

    // live conditions on the latest feedback sample
    logic ovf_now, ovw_now, uvw_now, uvf_now, ov_trip, uv_trip;
    assign ovf_now = (fb_r > thr_ovf) || (fb_r > FIXED_OV_MV);
    assign ovw_now = (fb_r > thr_ovw) || (fb_r > thr_pre);
    assign uvw_now = fb_r < thr_uvw;
    assign uvf_now = fb_r < thr_uvf;
    assign ov_trip = ovf_now && ov_act_r != ACT_IGNORE;
    assign uv_trip = uvf_now && uv_act_r != ACT_IGNORE && st_r == ST_RUN;

    // temperature comparisons
    logic bg_hot, bg_cool, ot_hot, ot_cool, ot_warn_now, ot_trip;
    logic [16:0] temp_up, bg_up;
    assign temp_up     = {1'b0, i_temp_c} + {1'b0, OT_HYST_C};
    assign bg_up       = {1'b0, i_bg_temp_c} + {1'b0, BG_HYST_C};
    assign bg_hot      = i_bg_valid && i_bg_temp_c > BG_SHUTDOWN_C;
    assign bg_cool     = i_bg_valid && bg_up <= {1'b0, BG_SHUTDOWN_C};
    assign ot_hot      = i_temp_valid && i_temp_c > ot_fault_r;
    assign ot_warn_now = i_temp_valid && i_temp_c > ot_warn_r;
    assign ot_cool     = i_temp_valid && temp_up <= {1'b0, ot_fault_r};
    assign ot_trip     = ot_hot && th_act_r != ACT_IGNORE;

    // timers: hiccup delay and start-up limit
    logic        hic_exp, ton_exp, ton_miss;
    logic [10:0] seven_rise;
    logic        enter_hic, enter_start;
    assign seven_rise  = ({3'b000, i_rise_ms} << 3) - {3'b000, i_rise_ms};
    assign enter_hic   = st_nxt == ST_HICCUP && st_r != ST_HICCUP;
    assign enter_start = st_nxt == ST_START && st_r != ST_START;
    assign ton_miss    = st_r == ST_START && ton_max_r != 16'h0000 && ton_exp;

    cfs_ms_timer #(.P_MS_CYCLES(P_MS_CYCLES)) u_hiccup (
        .i_ref_clk  (i_ref_clk),
        .i_resetn   (i_resetn),
        .i_ce       (i_ce),
        .i_start    (enter_hic),
        .i_limit_ms ({5'b00000, seven_rise}),
        .o_expired  (hic_exp)
    );
    cfs_ms_timer #(.P_MS_CYCLES(P_MS_CYCLES)) u_ton (
        .i_ref_clk  (i_ref_clk),
        .i_resetn   (i_resetn),
        .i_ce       (i_ce),
        .i_start    (enter_start),
        .i_limit_ms (ton_max_r),
        .o_expired  (ton_exp)
    );

    // sequence: a fault stops switching, the action picks what follows
    logic v_fault, cool_ok;
    cfs_action_e v_act;
    assign v_fault = ov_trip || uv_trip || (ton_miss && uv_act_r != ACT_IGNORE);
    assign v_act   = cfs_action_e'(ov_trip ? ov_act_r : uv_act_r);
    assign cool_ok = !bg_hold_r && !ot_hold_r;
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            ST_OFF:
                if (i_turn_on && cool_ok)
                    st_nxt = ST_START;
            ST_START, ST_RUN:
                if (bg_hold_r)
                    st_nxt = ST_COOL;
                else if (ot_hold_r)
                    st_nxt = (th_act_r == ACT_LATCH) ? ST_LATCH : ST_COOL;
                else if (v_fault)
                    st_nxt = (v_act == ACT_LATCH) ? ST_LATCH : ST_HICCUP;
                else if (!i_turn_on)
                    st_nxt = ST_OFF;
                else if (st_r == ST_START && (ton_miss || (i_ss_done && !uvf_now)))
                    st_nxt = ST_RUN;
            ST_HICCUP:
                if (!i_turn_on)
                    st_nxt = ST_OFF;
                else if (hic_exp && cool_ok)
                    st_nxt = ST_START;
            ST_COOL:
                if (cool_ok)
                    st_nxt = i_turn_on ? ST_START : ST_OFF;
            ST_LATCH:
                if (!i_turn_on)
                    st_nxt = ST_OFF;                                   // external reset
            default:
                st_nxt = ST_OFF;
        endcase
    end

    // status set terms; a set in the clearing cycle wins
    logic [7:0] th_set, vd_set, vo_set;
    assign th_set = {ot_hot, ot_warn_now, 6'h00};
    assign vd_set = {7'h00, bg_hot};
    assign vo_set = {ovf_now, ovw_now, uvw_now && st_r == ST_RUN,
                     uvf_now && st_r == ST_RUN, 1'b0, ton_miss, 2'b00};

    // good window and alert
    logic fault_any, pg_nxt, alert_nxt;
    assign fault_any = bg_hold_r || ot_hold_r || ovf_now || (uvf_now && st_r == ST_RUN);
    assign pg_nxt    = st_r == ST_RUN && !fault_any && !ovw_now && !uvw_now;
    assign alert_nxt = (|therm_st_r && !mask_r[MSK_THERM])
                    || (|vend_st_r && !mask_r[MSK_VENDOR])
                    || (|vout_st_r && !mask_r[MSK_VOUT]);

    // read mux
    logic [15:0] rd_nxt;
    always_comb
    begin
        case (i_cmd.code)
            CMD_OT_FAULT_LIM:  rd_nxt = ot_fault_r;
            CMD_OT_WARN_LIM:   rd_nxt = ot_warn_r;
            CMD_TON_MAX_LIM:   rd_nxt = ton_max_r;
            CMD_THERM_STATUS:  rd_nxt = {8'h00, therm_st_r};
            CMD_DIE_TEMP:      rd_nxt = die_temp_r;
            CMD_PCT_LIMITS:    rd_nxt = {8'h00, pct_r};
            CMD_THERM_ACTION:  rd_nxt = {14'h0000, th_act_r};
            CMD_OV_ACTION:     rd_nxt = {14'h0000, ov_act_r};
            CMD_UV_ACTION:     rd_nxt = {14'h0000, uv_act_r};
            CMD_ALERT_MASK:    rd_nxt = {8'h00, mask_r};
            CMD_VENDOR_STATUS: rd_nxt = {8'h00, vend_st_r};
            CMD_VOUT_STATUS:   rd_nxt = {8'h00, vout_st_r};
            CMD_VOUT_READING:  rd_nxt = vout_rd_r;
            default:           rd_nxt = 16'h0000;
        endcase
    end

    // configuration registers
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            ot_fault_r <= RST_OT_FAULT_LIM;
            ot_warn_r  <= RST_OT_WARN_LIM;
            ton_max_r  <= RST_TON_MAX_LIM;
            pct_r      <= RST_PCT_LIMITS;
            mask_r     <= RST_ALERT_MASK;
            th_act_r   <= ACT_IGNORE;
            ov_act_r   <= ACT_RESTART;
            uv_act_r   <= ACT_RESTART;
        end
        else if (i_ce)
        begin
            if (wr_otf) ot_fault_r <= i_cmd.wdata;
            if (wr_otw) ot_warn_r  <= i_cmd.wdata;
            if (wr_ton) ton_max_r  <= i_cmd.wdata;
            if (wr_pct) pct_r      <= i_cmd.wdata[7:0];
            if (wr_msk) mask_r     <= i_cmd.wdata[7:0];
            if (wr_tha) th_act_r   <= i_cmd.wdata[1:0];
            if (wr_ova) ov_act_r   <= i_cmd.wdata[1:0];
            if (wr_uva) uv_act_r   <= i_cmd.wdata[1:0];
        end
    end

    // sticky status, write one to clear
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            therm_st_r <= 8'h00;
            vend_st_r  <= 8'h00;
            vout_st_r  <= 8'h00;
        end
        else if (i_ce)
        begin
            therm_st_r <= (therm_st_r & ~({8{clr_th}} & i_cmd.wdata[7:0])) | th_set;
            vend_st_r  <= (vend_st_r & ~({8{clr_vd}} & i_cmd.wdata[7:0])) | vd_set;
            vout_st_r  <= (vout_st_r & ~({8{clr_vo}} & i_cmd.wdata[7:0])) | vo_set;
        end
    end

    // telemetry and thermal holds; four-sample block average cuts noise
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            die_temp_r <= 16'h0000;
            fb_r       <= 16'h0000;
            vout_rd_r  <= 16'h0000;
            avg_acc_r  <= 18'h0_0000;
            avg_cnt_r  <= 2'b00;
            bg_hold_r  <= 1'b0;
            ot_hold_r  <= 1'b0;
        end
        else if (i_ce)
        begin
            if (i_temp_valid) die_temp_r <= i_temp_c;
            if (i_fb_valid)
            begin
                fb_r      <= i_fb_mv;
                avg_cnt_r <= avg_cnt_r + 2'b01;
                avg_acc_r <= (avg_cnt_r == 2'b11) ? 18'h0_0000 : avg_acc_r + {2'b00, i_fb_mv};
                if (avg_cnt_r == 2'b11)
                    vout_rd_r <= 16'((avg_acc_r + {2'b00, i_fb_mv}) >> 2);
            end
            if (bg_hot)       bg_hold_r <= 1'b1;
            else if (bg_cool) bg_hold_r <= 1'b0;
            if (ot_trip)      ot_hold_r <= 1'b1;
            else if (ot_cool) ot_hold_r <= 1'b0;
        end
    end

    // state and registered pins
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st_r         <= ST_OFF;
            o_cmd_rdata  <= 16'h0000;
            o_conv_en    <= 1'b0;
            o_lowside_on <= 1'b0;
            o_smbalert_n <= 1'b1;
            o_pwr_ok_o   <= 1'b0;
            o_pwr_ok_oe  <= 1'b1;
        end
        else if (i_ce)
        begin
            st_r         <= st_nxt;
            o_cmd_rdata  <= i_cmd.rd ? rd_nxt : o_cmd_rdata;
            o_conv_en    <= st_nxt == ST_START || st_nxt == ST_RUN;
            o_lowside_on <= ov_trip;
            o_smbalert_n <= !alert_nxt;
            o_pwr_ok_o   <= 1'b0;                                      // open drain only pulls low
            o_pwr_ok_oe  <= !pg_nxt;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    a_bg_halts_conv: assert property (i_ce && bg_hot |=> ##1 !o_conv_en)
        else $error("bandgap trip did not stop conversion");
    a_bg_flag_set: assert property (i_ce && bg_hot |=> vend_st_r[BIT_BG_OT])
        else $error("bandgap flag not set");
    a_bg_stays_off: assert property (bg_hold_r && i_ce |=> !o_conv_en)
        else $error("conversion resumed while bandgap hold active");
    a_alert_follows: assert property (i_ce && |vend_st_r && !mask_r[MSK_VENDOR] |=> !o_smbalert_n)
        else $error("unmasked status did not raise alert");
    a_temp_refresh: assert property (i_ce && i_temp_valid |=> die_temp_r == $past(i_temp_c))
        else $error("temperature reading not refreshed");
    a_ot_flag_set: assert property (i_ce && ot_hot |=> therm_st_r[BIT_OT_FAULT])
        else $error("overtemperature fault flag missing");
    a_ov_lowside: assert property (i_ce && ovf_now && ov_act_r != ACT_IGNORE |=> o_lowside_on)
        else $error("low side not turned on at overvoltage");
    a_fixed_ov: assert property (i_ce && fb_r > FIXED_OV_MV |=> vout_st_r[BIT_OV_FAULT])
        else $error("fixed overvoltage level not flagged");
    a_uv_stops: assert property (i_ce && uv_trip && !bg_hold_r && !ot_hold_r |=> !o_conv_en)
        else $error("undervoltage did not stop switching");
    a_power_ok_output_gate: assert property (!o_pwr_ok_oe |-> $past(st_r) == ST_RUN)
        else $error("power good released outside run");
    a_flag_sticky: assert property (i_ce && vout_st_r[BIT_OV_FAULT] && !clr_vo |=> vout_st_r[BIT_OV_FAULT])
        else $error("status flag dropped without clear");

    c_hiccup: cover property (st_r == ST_RUN ##1 st_r == ST_HICCUP);
    c_latch:  cover property (st_r == ST_LATCH);
    c_cool:   cover property (st_r == ST_COOL ##[1:1000] st_r == ST_START);
    c_power_ok_output:  cover property ($fell(o_pwr_ok_oe));
endmodule : cfs_supervisor

// ===== shared/cfs_pkg.sv
/*
 * cfs_pkg: command codes, field layout, reset values, thresholds and timing
 * counts for the converter fault supervisor.
 * Assumes a 25 MHz converter clock and temperatures in whole degrees C.
 */
package cfs_pkg;

    // command codes of the registers
    localparam logic [7:0] CMD_OT_FAULT_LIM  = 8'h4F;
    localparam logic [7:0] CMD_OT_WARN_LIM   = 8'h51;
    localparam logic [7:0] CMD_TON_MAX_LIM   = 8'h62;
    localparam logic [7:0] CMD_THERM_STATUS  = 8'h7D;
    localparam logic [7:0] CMD_DIE_TEMP      = 8'h8D;
    localparam logic [7:0] CMD_PCT_LIMITS    = 8'hD7;
    localparam logic [7:0] CMD_THERM_ACTION  = 8'hE0;
    localparam logic [7:0] CMD_OV_ACTION     = 8'hE1;
    localparam logic [7:0] CMD_UV_ACTION     = 8'hE2;
    localparam logic [7:0] CMD_ALERT_MASK    = 8'hE3;
    localparam logic [7:0] CMD_VENDOR_STATUS = 8'hE4;
    localparam logic [7:0] CMD_VOUT_STATUS   = 8'hE5;
    localparam logic [7:0] CMD_VOUT_READING  = 8'hE6;

    // status bit positions
    localparam int BIT_OT_FAULT  = 7;   // thermal status
    localparam int BIT_OT_WARN   = 6;
    localparam int BIT_BG_OT     = 0;   // vendor status
    localparam int BIT_OV_FAULT  = 7;   // vout status
    localparam int BIT_OV_WARN   = 6;
    localparam int BIT_UV_WARN   = 5;
    localparam int BIT_UV_FAULT  = 4;
    localparam int BIT_TON_FAULT = 2;
    // alert mask bits: one per status byte
    localparam int MSK_THERM     = 0;
    localparam int MSK_VENDOR    = 1;
    localparam int MSK_VOUT      = 2;

    // percent-limit field positions, two bits each
    localparam int PCT_OVF_LSB   = 0;
    localparam int PCT_OVW_LSB   = 2;
    localparam int PCT_UVW_LSB   = 4;
    localparam int PCT_UVF_LSB   = 6;
    localparam int FAULT_SHIFT0  = 3;   // offset = vref >> (sel + base)
    localparam int WARN_SHIFT0   = 4;

    // reset values
    localparam logic [15:0] RST_OT_FAULT_LIM = 16'h007D;
    localparam logic [15:0] RST_OT_WARN_LIM  = 16'h0069;
    localparam logic [15:0] RST_TON_MAX_LIM  = 16'h0000;
    localparam logic [7:0]  RST_PCT_LIMITS   = 8'h00;
    localparam logic [7:0]  RST_ALERT_MASK   = 8'h00;

    // fixed protection levels
    localparam logic [15:0] BG_SHUTDOWN_C    = 16'h0091;   // 145 C
    localparam logic [15:0] BG_HYST_C        = 16'h0014;   // 20 C
    localparam logic [15:0] OT_HYST_C        = 16'h0014;   // 20 C
    localparam logic [15:0] FIXED_OV_MV      = 16'h0898;   // 2.2 V
    localparam logic [19:0] PREBIAS_NUM      = 20'h0_000D; // 13/256, about 5 %
    localparam int          HICCUP_RISES     = 7;

    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_NS         = 1_000_000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ACT_IGNORE  = 2'b00,
        ACT_LATCH   = 2'b01,
        ACT_RESTART = 2'b10
    } cfs_action_e;

    // gray walk: off -> start -> run -> hiccup -> cool -> latch
    typedef enum logic [2:0] {
        ST_OFF    = 3'b000,
        ST_START  = 3'b001,
        ST_RUN    = 3'b011,
        ST_HICCUP = 3'b010,
        ST_COOL   = 3'b110,
        ST_LATCH  = 3'b100
    } cfs_state_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  code;
        logic [15:0] wdata;
    } cfs_cmd_s;

endpackage : cfs_pkg

// ===== rtl/cfs_ms_timer.sv
/*
 * cfs_ms_timer: millisecond delay timer, restarted by a pulse, reports
 * when the programmed number of milliseconds has passed.
 * Assumes a single clock; i_ce freezes the count.
 */
`timescale 1ns/1ps
module cfs_ms_timer #(
    parameter int P_MS_CYCLES = cfs_pkg::MS_CYCLES
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_ce,
    input  wire logic        i_start,
    input  wire logic [15:0] i_limit_ms,
    output logic             o_expired
);
    localparam int CW = $clog2(P_MS_CYCLES);
    localparam logic [CW-1:0] LAST = CW'(P_MS_CYCLES - 1);

    logic [CW-1:0] cyc_r;
    logic [15:0]   ms_r;
    logic          tick;
    logic          done;

    assign tick = (cyc_r == LAST);
    assign done = (ms_r >= i_limit_ms);

    // saturate at the limit so a long wait never wraps
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cyc_r     <= '0;
            ms_r      <= '0;
            o_expired <= 1'b0;
        end
        else if (i_ce)
        begin
            if (i_start)
            begin
                cyc_r     <= '0;
                ms_r      <= '0;
                o_expired <= 1'b0;
            end
            else
            begin
                cyc_r     <= tick ? '0 : cyc_r + 1'b1;
                ms_r      <= (tick && !done) ? ms_r + 16'h0001 : ms_r;
                o_expired <= done;
            end
        end
    end
endmodule : cfs_ms_timer

// ===== verif/cfs_host_model.sv
/* host side of the command port, plus the power-good pull-up.
   assumes i_ref_clk and the cfs_pkg command layout. */
`timescale 1ns/1ps
module cfs_host_model
    import cfs_pkg::*;
(
    input  wire logic          i_ref_clk,
    input  wire logic [15:0]   i_rdata,
    input  wire logic          i_pwr_ok_o,
    input  wire logic          i_pwr_ok_oe,
    output cfs_pkg::cfs_cmd_s  o_cmd,
    output logic               o_pwr_ok
);
    // pull-up: line is high unless the device pulls it down
    assign o_pwr_ok = i_pwr_ok_oe ? i_pwr_ok_o : 1'b1;
    initial o_cmd = '0;
    // one-cycle strobe; idle fields show inverted junk, never stale data
    task automatic put(input logic [7:0] c, input logic [15:0] d);
        @(posedge i_ref_clk);
        o_cmd <= '{1'b1, 1'b0, c, d};
        @(posedge i_ref_clk);
        o_cmd <= '{1'b0, 1'b0, ~c, ~d};
    endtask : put
    task automatic get(input logic [7:0] c, output logic [15:0] d);
        @(posedge i_ref_clk);
        o_cmd <= '{1'b0, 1'b1, c, 16'h0000};
        @(posedge i_ref_clk);
        o_cmd <= '{1'b0, 1'b0, ~c, 16'hFFFF};
        @(posedge i_ref_clk);
        #1 d = i_rdata;
    endtask : get
endmodule : cfs_host_model

// ===== verif/cfs_supervisor_test.sv
/* self-checking bench for cfs_supervisor through its command port.
   assumes the host model above; short ms count keeps the run brief. */
`timescale 1ns/1ps
module cfs_supervisor_test;
    import cfs_pkg::*;
    logic i_ref_clk = 0, i_resetn = 0, i_tv = 0, i_bv = 0, i_fv = 0, i_on = 1, o_en, o_ls, o_al, o_oe, o_po, pw;
    logic [15:0] i_t = 0, i_b = 0, i_f = 0, o_rd;
    cfs_cmd_s    cmd;
    int          n_mismatch = 0;
    int          tests_run = 0;
    cfs_supervisor #(.P_MS_CYCLES(4)) dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_ce(1'b1),
        .i_cmd(cmd), .i_turn_on(i_on), .i_temp_valid(i_tv), .i_temp_c(i_t), .i_bg_valid(i_bv),
        .i_bg_temp_c(i_b), .i_fb_valid(i_fv), .i_fb_mv(i_f), .i_vref_mv(16'h03E8), .i_rise_ms(8'h01),
        .i_ss_done(1'b1), .o_cmd_rdata(o_rd), .o_conv_en(o_en), .o_lowside_on(o_ls),
        .o_smbalert_n(o_al), .o_pwr_ok_o(o_po), .o_pwr_ok_oe(o_oe));
    cfs_host_model host (.i_ref_clk(i_ref_clk), .i_rdata(o_rd), .i_pwr_ok_o(o_po), .i_pwr_ok_oe(o_oe),
        .o_cmd(cmd), .o_pwr_ok(pw));
    initial forever #20 i_ref_clk = ~i_ref_clk;
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // read a code, compare the masked bits
    task automatic rdc(input logic [7:0] c, input logic [15:0] m, input logic [15:0] e);
        logic [15:0] d;
        host.get(c, d);
        chk(d & m, e);
    endtask : rdc
    // one-cycle sample pulse; temp flags land 1 cycle on, feedback flags and conv_en 2 cycles on
    task automatic smp(input int k, input logic [15:0] v);
        @(posedge i_ref_clk);
        i_tv <= (k == 0); i_bv <= (k == 1); i_fv <= (k == 2);
        i_t <= v; i_b <= v; i_f <= v;
        @(posedge i_ref_clk);
        i_tv <= 0; i_bv <= 0; i_fv <= 0;
        repeat (3) @(posedge i_ref_clk);
        #1;
    endtask : smp
    task automatic tally_and_finish;
        if (n_mismatch == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (2) @(posedge i_ref_clk);
        i_resetn <= 1;
        rdc(CMD_OT_FAULT_LIM, 16'hFFFF, 16'h007D);
        rdc(CMD_OT_WARN_LIM, 16'hFFFF, 16'h0069);
        rdc(CMD_THERM_ACTION, 16'hFFFF, 16'h0000);
        rdc(8'h99, 16'hFFFF, 16'h0000);
        host.put(CMD_OT_WARN_LIM, 16'h0032);
        smp(0, 16'h003C);
        host.put(CMD_DIE_TEMP, 16'h0000);
        rdc(CMD_DIE_TEMP, 16'hFFFF, 16'h003C);
        rdc(CMD_THERM_STATUS, 16'h00FF, 16'h0040);
        chk(o_al, 1'b0);
        host.put(CMD_OT_FAULT_LIM, 16'h0046);
        host.put(CMD_THERM_ACTION, 16'h0001);
        smp(0, 16'h0050);
        rdc(CMD_THERM_STATUS, 16'h00FF, 16'h00C0);
        chk(o_en, 1'b0);
        chk(pw, 1'b0);
        host.put(CMD_THERM_STATUS, 16'h00C0);
        rdc(CMD_THERM_STATUS, 16'h00FF, 16'h0000);
        host.put(CMD_ALERT_MASK, 16'h0001);
        smp(1, 16'h0096);
        rdc(CMD_VENDOR_STATUS, 16'h0001, 16'h0001);
        chk(o_en, 1'b0);
        chk(o_al, 1'b0);
        host.put(CMD_ALERT_MASK, 16'h0007);
        host.put(CMD_VENDOR_STATUS, 16'h0001);
        smp(1, 16'h0096);
        chk(o_al, 1'b1);
        rdc(CMD_VENDOR_STATUS, 16'h0001, 16'h0001);
        foreach (i_f[i]) if (i < 4) smp(2, 16'h03E8 + 16'(i * 4));
        rdc(CMD_VOUT_READING, 16'hFFFF, 16'h03EE);
        smp(2, 16'h08FC);
        chk(o_ls, 1'b1);
        rdc(CMD_VOUT_STATUS, 16'h0080, 16'h0080);
        // cool down, drop the latch with turn-on low, come up into run
        smp(0, 16'h0028);
        smp(1, 16'h0064);
        smp(2, 16'h03E8);
        chk(o_ls, 1'b0);
        @(posedge i_ref_clk);
        i_on <= 1'b0;
        @(posedge i_ref_clk);
        i_on <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        #1;
        chk(o_en, 1'b1);
        chk(pw, 1'b1);
        // undervoltage in run: both off, then hiccup for seven rise times
        smp(2, 16'h0320);
        chk(o_en, 1'b0);
        chk(pw, 1'b0);
        rdc(CMD_VOUT_STATUS, 16'h0030, 16'h0030);
        repeat (20) @(posedge i_ref_clk);
        #1;
        chk(o_en, 1'b0);
        repeat (8) @(posedge i_ref_clk);
        #1;
        chk(o_en, 1'b1);
        smp(2, 16'h03E8);
        chk(pw, 1'b1);
        host.put(CMD_VOUT_STATUS, 16'h00FF);
        // prebias just above 5 %, below the warn preset
        smp(2, 16'h041F);
        chk(pw, 1'b0);
        rdc(CMD_VOUT_STATUS, 16'h0040, 16'h0040);
        smp(2, 16'h03E8);
        host.put(CMD_PCT_LIMITS, 16'h000C);
        smp(2, 16'h0406);
        chk(pw, 1'b0);
        tally_and_finish();
    end
endmodule : cfs_supervisor_test
